// ---- design/bus_status_pkg.sv ----
// Shared types and constants for the cycle-status and request/grant logic.
// Assumes one 50 MHz clock and a single asynchronous, active-high reset.
package bus_status_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus cycle states; BUS_IDLE is the idle slot between cycles
   typedef enum logic [2:0] {
      BUS_IDLE,
      BUS_STATE_FIRST,
      BUS_STATE_SECOND,
      BUS_STATE_THIRD,
      BUS_WAIT_STATE,
      BUS_STATE_FOURTH,
      BUS_HELD
   } bus_state_t;

   typedef struct packed {
      logic cycle_status_bit2;
      logic cycle_status_bit1;
      logic cycle_status_bit0;
   } cycle_status_t;

   ////////////////////////////////////////////////////////////////////////////
   // Cycle-status codes
   localparam logic [2:0] CODE_INT_ACK = 3'h0;
   localparam logic [2:0] CODE_IO_READ = 3'h1;
   localparam logic [2:0] CODE_IO_WRITE = 3'h2;
   localparam logic [2:0] CODE_HALT = 3'h3;
   localparam logic [2:0] CODE_FETCH = 3'h4;
   localparam logic [2:0] CODE_MEM_READ = 3'h5;
   localparam logic [2:0] CODE_MEM_WRITE = 3'h6;
   localparam logic [2:0] CODE_PASSIVE = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and timing
   localparam logic RESET_STATUS_OE = 1'b1;
   localparam logic RESET_PIN_LEVEL = 1'b1;
   localparam int PULSE_CYCLES = 1;

endpackage

// ---- design/req_grant_pin.sv ----
// One two-way request/grant pin: spots incoming low pulses and drives
// a one-clock low grant pulse. Assumes the wire idles high when undriven.
`timescale 1ns/10ps
module req_grant_pin (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic pin_in,
   input wire logic fire,
   output logic pin_out,
   output logic pin_oe,
   output logic pulse_seen
);
   import bus_status_pkg::*;

   typedef struct packed {
      logic prev_in;
      logic drive;
      logic blank;
   } pin_state_t;

   pin_state_t s;
   pin_state_t next_s;

   // Masking and grant drive are built for one-clock pulses only
   if (PULSE_CYCLES != 1) begin : g_bad_pulse
      $error("grant pulse logic serves one-cycle pulses only");
   end

   // Own pulse and the cycle after it are masked so they never look like a request
   assign pulse_seen = s.prev_in & ~pin_in & ~s.drive & ~s.blank;

   always_comb begin
      next_s = s;
      next_s.prev_in = pin_in;
      next_s.drive = fire;
      next_s.blank = s.drive;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s <= '{prev_in: RESET_PIN_LEVEL, drive: 1'b0, blank: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign pin_out = 1'b0;
   assign pin_oe = s.drive;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_idle_no_req: assert property (pin_in |-> !pulse_seen)
      else $error("request seen on a high pin");
   a_grant_one_wide: assert property ($rose(pin_oe) |=> !pin_oe)
      else $error("grant pulse wider than one clock");

endmodule // req_grant_pin

// ---- design/bus_status_grant.sv ----
// Cycle-status outputs and two request/grant pins of a maximum-mode local
// bus. Assumes the core offers cycles via cycle_start/cycle_kind and that
// the environment resolves each two-way pin from its enable, pulled high.
//
// Contract
// - Status returns to passive in third or wait state once ready is high.
// - Leaving passive in fourth state starts a cycle; returning passive ends it.
// - During a grant sequence the status outputs float, weakly held high.
// - The bus is released only at the end of the current cycle.
// - Pins are two-way; high-priority pin wins when both request together.
// - An unconnected pin idles high and never shows a request.
// - The device answers with a one-clock pulse during fourth or first state; the code pulses only in the fourth state.
`timescale 1ns/10ps
module bus_status_grant (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ready,
   input wire logic cycle_start,
   input wire logic [2:0] cycle_kind,
   output logic cycle_taken,
   output bus_status_pkg::cycle_status_t cycle_status,
   output logic cycle_status_oe,
   output bus_status_pkg::bus_state_t bus_state,
   input wire logic high_prio_req_grant_in,
   output logic high_prio_req_grant_out,
   output logic high_prio_req_grant_oe,
   input wire logic low_prio_req_grant_in,
   output logic low_prio_req_grant_out,
   output logic low_prio_req_grant_oe
);
   import bus_status_pkg::*;

   typedef struct packed {
      bus_state_t st;
      cycle_status_t status;
      logic status_oe;
      logic pend_hi;
      logic pend_lo;
      logic owner_hi;
      logic granting;
      logic taken;
   } main_state_t;

   main_state_t s;
   main_state_t next_s;
   logic seen_hi;
   logic seen_lo;
   logic fire_hi;
   logic fire_lo;
   logic release_seen;
   logic fire_any;

   ////////////////////////////////////////////////////////////////////////////
   // Pins

   req_grant_pin u_high_pin (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin_in(high_prio_req_grant_in),
      .fire(fire_hi),
      .pin_out(high_prio_req_grant_out),
      .pin_oe(high_prio_req_grant_oe),
      .pulse_seen(seen_hi)
   );

   req_grant_pin u_low_pin (
      .ref_clk(ref_clk),
      .rst(rst),
      .pin_in(low_prio_req_grant_in),
      .fire(fire_lo),
      .pin_out(low_prio_req_grant_out),
      .pin_oe(low_prio_req_grant_oe),
      .pulse_seen(seen_lo)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration: grants are only decided at a cycle boundary

   always_comb begin
      fire_any = 1'b0;
      if (!s.granting && (s.pend_hi || s.pend_lo)) begin
         if (s.st == BUS_IDLE || s.st == BUS_STATE_FOURTH) begin
            fire_any = 1'b1;
         end else if ((s.st == BUS_STATE_THIRD || s.st == BUS_WAIT_STATE) && ready) begin
            fire_any = 1'b1;
         end
      end
      fire_hi = fire_any & s.pend_hi;
      fire_lo = fire_any & ~s.pend_hi & s.pend_lo;
      release_seen = (s.st == BUS_HELD) && (s.owner_hi ? seen_hi : seen_lo);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus cycle sequencer

   always_comb begin
      next_s = s;
      next_s.taken = 1'b0;
      // A fresh pulse sets pending even in the cycle a grant clears it
      next_s.pend_hi = (s.pend_hi & ~fire_hi) | (seen_hi & ~(release_seen & s.owner_hi));
      next_s.pend_lo = (s.pend_lo & ~fire_lo) | (seen_lo & ~(release_seen & ~s.owner_hi));
      if (fire_any) begin
         next_s.granting = 1'b1;
         next_s.owner_hi = fire_hi;
      end
      case (s.st)
         BUS_IDLE: begin
            // Every cycle start and every grant passes through the fourth state
            if (fire_any || cycle_start) begin
               next_s.st = BUS_STATE_FOURTH;
            end
         end
         BUS_STATE_FOURTH: begin
            if (s.granting) begin
               next_s.st = BUS_HELD;
               next_s.status_oe = 1'b0;
               next_s.granting = 1'b0;
            end else if (fire_any) begin
               next_s.st = BUS_STATE_FOURTH;
            end else if (cycle_start) begin
               next_s.st = BUS_STATE_FIRST;
               next_s.status = cycle_kind;
               next_s.taken = 1'b1;
            end else begin
               next_s.st = BUS_IDLE;
            end
         end
         BUS_STATE_FIRST: begin
            next_s.st = BUS_STATE_SECOND;
         end
         BUS_STATE_SECOND: begin
            next_s.st = BUS_STATE_THIRD;
         end
         BUS_STATE_THIRD, BUS_WAIT_STATE: begin
            if (ready) begin
               next_s.status = CODE_PASSIVE;
               next_s.st = BUS_STATE_FOURTH;
            end else begin
               next_s.st = BUS_WAIT_STATE;
            end
         end
         BUS_HELD: begin
            next_s.status_oe = 1'b0;
            if (release_seen) begin
               next_s.st = BUS_IDLE;
               next_s.status = CODE_PASSIVE;
               next_s.status_oe = 1'b1;
            end
         end
         default: begin
            next_s.st = BUS_IDLE;
            next_s.status = CODE_PASSIVE;
            next_s.status_oe = RESET_STATUS_OE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s <= '{st: BUS_IDLE, status: CODE_PASSIVE, status_oe: RESET_STATUS_OE,
                pend_hi: 1'b0, pend_lo: 1'b0, owner_hi: 1'b0, granting: 1'b0,
                taken: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign cycle_status = s.status;
   assign cycle_status_oe = s.status_oe;
   assign bus_state = s.st;
   assign cycle_taken = s.taken;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_passive_on_ready: assert property (
      (s.st == BUS_STATE_THIRD || s.st == BUS_WAIT_STATE) && ready
      |=> s.status == CODE_PASSIVE && s.st == BUS_STATE_FOURTH)
      else $error("status not passive after ready");
   a_start_in_fourth: assert property (
      $changed(s.status) && s.status != CODE_PASSIVE |-> $past(s.st) == BUS_STATE_FOURTH)
      else $error("cycle started outside fourth state");
   a_status_held_cycle: assert property (
      s.st == BUS_STATE_FIRST |=> $stable(s.status) [*2])
      else $error("status moved inside a cycle");
   a_float_in_hold: assert property (s.st == BUS_HELD |-> !cycle_status_oe)
      else $error("status driven while bus is held");
   a_release_at_end: assert property (
      $rose(s.st == BUS_HELD) |-> $past(s.st) == BUS_STATE_FOURTH && $past(s.granting))
      else $error("bus released mid cycle");
   a_high_first: assert property (
      fire_any && s.pend_hi && s.pend_lo |=> high_prio_req_grant_oe && !low_prio_req_grant_oe)
      else $error("low priority pin served first");
   a_grant_in_fourth: assert property (
      high_prio_req_grant_oe || low_prio_req_grant_oe |-> s.st == BUS_STATE_FOURTH)
      else $error("grant pulse outside fourth state");
   a_code_taken: assert property (
      cycle_taken |-> s.status == $past(cycle_kind) && s.st == BUS_STATE_FIRST)
      else $error("status code differs from requested kind");
   a_resume_drive: assert property (
      release_seen |=> cycle_status_oe && s.status == CODE_PASSIVE && s.st == BUS_IDLE)
      else $error("driving not resumed after return pulse");

endmodule // bus_status_grant

// ---- bench/bus_master_model.sv ----
// Another local bus master on one request/grant pin.
// Assumes the bench resolves the wire low-wins with a pull-up.
`timescale 1ns/10ps
module bus_master_model (
   input wire logic ref_clk,
   input wire logic go,
   output logic drv_low
);
   initial drv_low = 1'b0;
   // Low drive follows go one falling edge later and lasts as long as go is held, then the pin is let go
   always @(negedge ref_clk) begin
      drv_low <= go;
   end
endmodule // bus_master_model

// ---- bench/tb_bus_status_grant.sv ----
// Self-checking bench for the cycle-status and request/grant logic.
// Assumes bus_status_pkg is compiled first; both pins resolve with pull-ups.
`timescale 1ns/10ps
module tb_bus_status_grant;
   import bus_status_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic ready = 1'b0;
   logic cycle_start = 1'b0;
   logic [2:0] cycle_kind = 3'h0;
   logic [1:0] go = 2'h0;
   logic [1:0] drv;
   logic cycle_taken, cycle_status_oe, hp_out, hp_oe, lp_out, lp_oe, hp_wire, lp_wire;
   logic [2:0] status_wire;
   cycle_status_t cycle_status;
   bus_state_t bus_state;
   logic [3:0] expq[$];
   logic [3:0] seen;
   logic [31:0] seed = 32'h00015007;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;

   always #10 ref_clk = ~ref_clk;
   // Undriven wires float high, like the internal hold circuit
   assign hp_wire = ~((hp_oe & ~hp_out) | drv[0]);
   assign lp_wire = ~((lp_oe & ~lp_out) | drv[1]);
   // What the external controller decodes its strobes from
   assign status_wire = cycle_status_oe ? cycle_status : 3'h7;

   bus_status_grant uut (.ref_clk(ref_clk), .rst(rst), .ready(ready),
      .cycle_start(cycle_start), .cycle_kind(cycle_kind), .cycle_taken(cycle_taken),
      .cycle_status(cycle_status), .cycle_status_oe(cycle_status_oe), .bus_state(bus_state),
      .high_prio_req_grant_in(hp_wire), .high_prio_req_grant_out(hp_out),
      .high_prio_req_grant_oe(hp_oe), .low_prio_req_grant_in(lp_wire),
      .low_prio_req_grant_out(lp_out), .low_prio_req_grant_oe(lp_oe));
   bus_master_model hp_master (.ref_clk(ref_clk), .go(go[0]), .drv_low(drv[0]));
   bus_master_model lp_master (.ref_clk(ref_clk), .go(go[1]), .drv_low(drv[1]));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] r;
      r = v ^ (v << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction

   task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wait_state(input bus_state_t s);
      int n;
      n = 0;
      while (bus_state !== s && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 50) chk("state wait", {1'b0, s}, {1'b0, bus_state});
   endtask

   task automatic do_cycle(input logic [2:0] kind, input int waits);
      expq.push_back({1'b0, kind});
      cycle_start = 1'b1;
      cycle_kind = kind;
      wait_state(BUS_STATE_FIRST);
      cycle_start = 1'b0;
      wait_state(BUS_STATE_THIRD);
      repeat (waits) @(negedge ref_clk);
      chk("status held", {1'b0, kind}, {1'b0, status_wire});
      ready = 1'b1;
      @(negedge ref_clk);
      ready = 1'b0;
      chk("status passive", {1'b0, CODE_PASSIVE}, {1'b0, cycle_status});
   endtask

   task automatic pulse(input int p);
      go[p] <= 1'b1;
      @(negedge ref_clk);
      go[p] <= 1'b0;
   endtask

   // Holds the bus a few clocks, then hands it back
   task automatic hold(input int p);
      wait_state(BUS_HELD);
      chk("status float", 4'h0, {3'h0, cycle_status_oe});
      chk("status wire", 4'h7, {1'b0, status_wire});
      repeat (3) @(negedge ref_clk);
      // Return pulse is on the wire but not yet sampled by the device
      pulse(p);
      chk("still held", 4'h0, {3'h0, cycle_status_oe});
      @(negedge ref_clk);
      chk("drive resumed", 4'h1, {3'h0, cycle_status_oe});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Every cycle start or grant pulse is matched against the oldest note
   always @(negedge ref_clk) begin
      if (!rst && (cycle_taken === 1'b1 || hp_oe === 1'b1 || lp_oe === 1'b1)) begin
         seen = (cycle_taken === 1'b1) ? {1'b0, cycle_status} : (hp_oe ? 4'h8 : 4'h9);
         if (expq.size() == 0) chk("unexpected", 4'hf, seen);
         else chk("result order", expq.pop_front(), seen);
         if (cycle_taken !== 1'b1) begin
            chk("grant state", {1'b0, BUS_STATE_FOURTH}, {1'b0, bus_state});
         end
      end
   end

   // Whole run needs well under a thousand clocks
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      for (int k = 0; k < 7; k++) begin
         do_cycle(3'(k), k % 3);
      end
      $display("test codes done");
      for (int k = 0; k < 10; k++) begin
         seed = xs(seed);
         do_cycle(3'(seed % 7), int'(seed[9:8]));
      end
      $display("test random cycles done");
      for (int p = 0; p < 2; p++) begin
         expq.push_back(4'(8 + p));
         pulse(p);
         hold(p);
      end
      $display("test idle grants done");
      expq.push_back(4'h8);
      expq.push_back(4'h9);
      go <= 2'h3;
      @(negedge ref_clk);
      go <= 2'h0;
      hold(0);
      hold(1);
      $display("test priority done");
      fork
         do_cycle(CODE_MEM_READ, 4);
         begin
            repeat (3) @(negedge ref_clk);
            expq.push_back(4'h8);
            pulse(0);
         end
      join
      hold(0);
      $display("test mid-cycle request done");
      chk("notes left", 4'h0, 4'(expq.size()));
      report_and_stop();
   end
endmodule // tb_bus_status_grant
